// *** inc/trd_defines.svh ***
`ifndef TRD_DEFINES_SVH
`define TRD_DEFINES_SVH

// Chain select indices
`define TRD_SEL_RANGE_BASE  8'h30
`define TRD_SEL_R1_LOWER    8'h30
`define TRD_SEL_R1_UPPER    8'h31
`define TRD_SEL_R2_LOWER    8'h32
`define TRD_SEL_R2_UPPER    8'h33
`define TRD_SEL_EDGE1       8'h34
`define TRD_SEL_EDGE2       8'h35
`define TRD_SEL_T1_LIM_LOW  8'h38
`define TRD_SEL_T1_LIM_HIGH 8'h39
`define TRD_SEL_T2_LIM_LOW  8'h3A
`define TRD_SEL_T2_LIM_HIGH 8'h3B

// Chain geometry
`define TRD_WORD_BITS       32
`define TRD_CELL_BITS       16
`define TRD_RANGE_CELLS     32
`define TRD_RANGE_BITS      512
`define TRD_EDGE_CELLS      16
`define TRD_EDGE_BITS       256
`define TRD_TMR_BITS        36
`define TRD_TMR_HIGH_BITS   4

// Cell patterns
`define TRD_CMP_TARGET_ZERO 16'hAAAA
`define TRD_CMP_TARGET_ONE  16'h5555
`define TRD_CMP_PASSTHROUGH 16'hFFFF
`define TRD_RISE_LOW_BIT    16'h0A0A
`define TRD_FALL_LOW_BIT    16'h5050
`define TRD_RISE_HIGH_BIT   16'h00CC
`define TRD_FALL_HIGH_BIT   16'h3300

// Reset values and last shift count
`define TRD_SEL_RESET       8'h00
`define TRD_TMR_LIM_RESET   36'h000000000
`define TRD_SHIFT_CNT_LAST  5'h1F

// Timer tick
`define TRD_TMR_TICK_NS     10

`endif

// *** inc/trd_pkg.sv ***
package trd_pkg;

  typedef struct packed {
    logic [1:0] range1;   // [1] upper hit, [0] lower hit
    logic [1:0] range2;
    logic       edge1;
    logic       edge2;
    logic       timer1;
    logic       timer2;
  } trd_hits_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic clear;
  } trd_tmr_cmd_t;

  typedef enum logic {
    TRD_SHIFT_IDLE,
    TRD_SHIFT_RUN
  } trd_shift_state_t;

endpackage : trd_pkg

// *** hdl/trd_detectors.sv ***
`timescale 1ns/1ps
`include "trd_defines.svh"
module trd_detectors
  import trd_pkg::*;
(
  input  wire logic         i_clk_sys,     // System clock
  input  wire logic         i_rst_n,       // Async reset, active low
  input  wire logic         i_sel_we,      // Chain select write strobe
  input  wire logic [7:0]   i_sel_data,    // Chain select value
  input  wire logic         i_chain_we,    // Chain data write strobe
  input  wire logic [31:0]  i_chain_data,  // Chain data word
  input  wire logic [31:0]  i_sample,      // Sample, same clock domain
  input  wire trd_tmr_cmd_t i_tmr1_cmd,    // Timer 1 sequencer command
  input  wire trd_tmr_cmd_t i_tmr2_cmd,    // Timer 2 sequencer command
  output trd_hits_t         o_hits,        // Hits to trigger sums
  output logic              o_busy         // Chain shift in progress
);

  // Carry chain magnitude compare; returns final carry-out
  function automatic logic range_carry(input logic [511:0] ch,
                                       input logic [31:0]  s);
    logic c;
    logic p;
    c = 1'b0;
    p = 1'b0;
    for (int k = 0; k < `TRD_RANGE_CELLS; k++) begin
      p = ch[k*`TRD_CELL_BITS + {3'b000, s[k]}];
      c = p ? c : s[k];
    end
    return c;
  endfunction : range_carry

  // Any edge cell firing
  function automatic logic edge_any(input logic [255:0] ch,
                                    input logic [31:0]  cur,
                                    input logic [31:0]  dly);
    logic       h;
    logic [3:0] a;
    h = 1'b0;
    a = 4'h0;
    for (int j = 0; j < `TRD_EDGE_CELLS; j++) begin
      a = {dly[2*j+1], dly[2*j], cur[2*j+1], cur[2*j]};
      h = h | ch[j*`TRD_CELL_BITS + a];
    end
    return h;
  endfunction : edge_any

  // Reset release
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // Chain select
  logic [7:0] sel_reg;

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sel_reg <= `TRD_SEL_RESET;
    end else if (i_sel_we) begin
      sel_reg <= i_sel_data;
    end
  end

  // Serial loader
  trd_shift_state_t shift_state_reg;
  logic [4:0]       shift_cnt_reg;
  logic [31:0]      shift_word_reg;
  logic [7:0]       shift_sel_reg;
  logic             shift_bit;
  logic             chain_sel_ok;
  logic             word_take;

  assign chain_sel_ok = (sel_reg >= `TRD_SEL_R1_LOWER) &&
                        (sel_reg <= `TRD_SEL_EDGE2);
  assign word_take    = i_chain_we && (shift_state_reg == TRD_SHIFT_IDLE);
  assign shift_bit    = shift_word_reg[31 - shift_cnt_reg];

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      shift_state_reg <= TRD_SHIFT_IDLE;
      shift_cnt_reg   <= 5'h00;
      shift_word_reg  <= 32'h0000_0000;
      shift_sel_reg   <= `TRD_SEL_RESET;
    end else begin
      case (shift_state_reg)
        TRD_SHIFT_IDLE: begin
          if (word_take && chain_sel_ok) begin
            shift_state_reg <= TRD_SHIFT_RUN;
            shift_cnt_reg   <= 5'h00;
            shift_word_reg  <= i_chain_data;
            shift_sel_reg   <= sel_reg;
          end
        end
        TRD_SHIFT_RUN: begin
          shift_cnt_reg <= shift_cnt_reg + 5'h01;
          if (shift_cnt_reg == `TRD_SHIFT_CNT_LAST) begin
            shift_state_reg <= TRD_SHIFT_IDLE;
          end
        end
        default: begin
          shift_state_reg <= TRD_SHIFT_IDLE;
        end
      endcase
    end
  end

  // Lookup chains; cell k occupies bits [16k+15:16k]
  logic [511:0] r1_lo_reg;
  logic [511:0] r1_hi_reg;
  logic [511:0] r2_lo_reg;
  logic [511:0] r2_hi_reg;
  logic [255:0] e1_reg;
  logic [255:0] e2_reg;
  logic         shifting;

  assign shifting = (shift_state_reg == TRD_SHIFT_RUN);

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      r1_lo_reg <= '0;
      r1_hi_reg <= '0;
      r2_lo_reg <= '0;
      r2_hi_reg <= '0;
      e1_reg    <= '0;
      e2_reg    <= '0;
    end else if (shifting) begin
      case (shift_sel_reg)
        `TRD_SEL_R1_LOWER: r1_lo_reg <= {r1_lo_reg[510:0], shift_bit};
        `TRD_SEL_R1_UPPER: r1_hi_reg <= {r1_hi_reg[510:0], shift_bit};
        `TRD_SEL_R2_LOWER: r2_lo_reg <= {r2_lo_reg[510:0], shift_bit};
        `TRD_SEL_R2_UPPER: r2_hi_reg <= {r2_hi_reg[510:0], shift_bit};
        `TRD_SEL_EDGE1:    e1_reg    <= {e1_reg[254:0], shift_bit};
        `TRD_SEL_EDGE2:    e2_reg    <= {e2_reg[254:0], shift_bit};
        default: begin
        end
      endcase
    end
  end

  // Timer limits, written directly
  logic [35:0] t1_lim_reg;
  logic [35:0] t2_lim_reg;

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      t1_lim_reg <= `TRD_TMR_LIM_RESET;
      t2_lim_reg <= `TRD_TMR_LIM_RESET;
    end else if (word_take) begin
      case (sel_reg)
        `TRD_SEL_T1_LIM_LOW:  t1_lim_reg[31:0]  <= i_chain_data;
        `TRD_SEL_T1_LIM_HIGH: t1_lim_reg[35:32] <= i_chain_data[3:0];
        `TRD_SEL_T2_LIM_LOW:  t2_lim_reg[31:0]  <= i_chain_data;
        `TRD_SEL_T2_LIM_HIGH: t2_lim_reg[35:32] <= i_chain_data[3:0];
        default: begin
        end
      endcase
    end
  end

  // Sample and delayed sample
  logic [31:0] sample_reg;
  logic [31:0] delayed_sample_bit_reg;

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sample_reg             <= 32'h0000_0000;
      delayed_sample_bit_reg <= 32'h0000_0000;
    end else begin
      sample_reg             <= i_sample;
      delayed_sample_bit_reg <= sample_reg;
    end
  end

  // Timers
  logic [35:0] t1_cnt_reg;
  logic [35:0] t2_cnt_reg;
  logic        t1_run_reg;
  logic        t2_run_reg;

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      t1_run_reg <= 1'b0;
      t1_cnt_reg <= 36'h000000000;
    end else begin
      if (i_tmr1_cmd.start) begin
        t1_run_reg <= 1'b1;
      end else if (i_tmr1_cmd.stop) begin
        t1_run_reg <= 1'b0;
      end
      if (i_tmr1_cmd.clear) begin
        t1_cnt_reg <= 36'h000000000;
      end else if (t1_run_reg && (t1_cnt_reg != '1)) begin
        t1_cnt_reg <= t1_cnt_reg + 36'h000000001;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      t2_run_reg <= 1'b0;
      t2_cnt_reg <= 36'h000000000;
    end else begin
      if (i_tmr2_cmd.start) begin
        t2_run_reg <= 1'b1;
      end else if (i_tmr2_cmd.stop) begin
        t2_run_reg <= 1'b0;
      end
      if (i_tmr2_cmd.clear) begin
        t2_cnt_reg <= 36'h000000000;
      end else if (t2_run_reg && (t2_cnt_reg != '1)) begin
        t2_cnt_reg <= t2_cnt_reg + 36'h000000001;
      end
    end
  end

  // Hit outputs
  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_hits <= '0;
    end else begin
      o_hits.range1[0] <= range_carry(r1_lo_reg, sample_reg);
      o_hits.range1[1] <= ~range_carry(r1_hi_reg, sample_reg);
      o_hits.range2[0] <= range_carry(r2_lo_reg, sample_reg);
      o_hits.range2[1] <= ~range_carry(r2_hi_reg, sample_reg);
      o_hits.edge1  <= edge_any(e1_reg, sample_reg,
                                delayed_sample_bit_reg);
      o_hits.edge2  <= edge_any(e2_reg, sample_reg,
                                delayed_sample_bit_reg);
      o_hits.timer1 <= ~i_tmr1_cmd.clear &&
                       (t1_cnt_reg >= t1_lim_reg);
      o_hits.timer2 <= ~i_tmr2_cmd.clear &&
                       (t2_cnt_reg >= t2_lim_reg);
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (shift_state_reg == TRD_SHIFT_IDLE) ?
                (word_take && chain_sel_ok) :
                (shift_cnt_reg != `TRD_SHIFT_CNT_LAST);
    end
  end

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n_reg);

  a_shift_length: assert property (
    $rose(shifting) |-> ##31 shifting ##1 !shifting)
    else $error("chain shift not 32 cycles");

  a_shift_msb_first: assert property (
    $rose(shifting) |-> shift_bit == shift_word_reg[31])
    else $error("chain shift did not start at bit 31");

  a_busy_refuse: assert property (
    shifting && i_chain_we |=> $stable(t1_lim_reg) && $stable(t2_lim_reg))
    else $error("limit changed during chain shift");

  a_limit_low_write: assert property (
    word_take && sel_reg == `TRD_SEL_T1_LIM_LOW
    |=> t1_lim_reg[31:0] == $past(i_chain_data))
    else $error("timer 1 low limit not written");

  a_limit_high_write: assert property (
    word_take && sel_reg == `TRD_SEL_T2_LIM_HIGH
    |=> t2_lim_reg[35:32] == $past(i_chain_data[3:0]))
    else $error("timer 2 high limit not written");

  a_range_chain_load: assert property (
    shifting && shift_sel_reg == `TRD_SEL_R2_UPPER
    |=> r2_hi_reg[0] == $past(shift_bit) && $stable(r1_lo_reg))
    else $error("wrong range chain loaded");

  a_timer_clear_zero: assert property (
    i_tmr1_cmd.clear |=> t1_cnt_reg == 36'h000000000 && !o_hits.timer1)
    else $error("timer clear ignored");

  a_timer_tick: assert property (
    t2_run_reg && !i_tmr2_cmd.clear && t2_cnt_reg != '1
    |=> t2_cnt_reg == $past(t2_cnt_reg) + 36'h000000001)
    else $error("timer did not advance one tick");

  a_timer_stop_hold: assert property (
    !t1_run_reg && !i_tmr1_cmd.start && !i_tmr1_cmd.clear
    |=> $stable(t1_cnt_reg))
    else $error("stopped timer moved");

  a_timer_hit_limit: assert property (
    o_hits.timer2 |-> $past(t2_cnt_reg) >= $past(t2_lim_reg))
    else $error("timer hit below limit");

  a_edge_delay: assert property (
    1'b1 |=> delayed_sample_bit_reg == $past(sample_reg))
    else $error("delayed sample lags wrongly");

  a_select_take: assert property (
    i_sel_we |=> sel_reg == $past(i_sel_data))
    else $error("chain select not taken");

  a_busy_shift: assert property (
    shifting |-> o_busy)
    else $error("busy low during chain shift");

  a_timer_start: assert property (
    i_tmr1_cmd.start |=> t1_run_reg)
    else $error("timer start ignored");

  a_timer_stop: assert property (
    i_tmr1_cmd.stop && !i_tmr1_cmd.start |=> !t1_run_reg)
    else $error("timer stop ignored");

  a_timer_hit_set: assert property (
    t1_cnt_reg >= t1_lim_reg && !i_tmr1_cmd.clear |=> o_hits.timer1)
    else $error("timer hit missing at limit");

endmodule : trd_detectors

// *** dv/trd_host_model.sv ***
`timescale 1ns/1ps
`include "trd_defines.svh"
module trd_host_model
  import trd_pkg::*;
(
  input  wire logic    i_clk_sys,    // System clock
  input  wire logic    i_busy,       // Loader busy
  output logic         o_sel_we,     // Select strobe
  output logic [7:0]   o_sel_data,   // Select index
  output logic         o_chain_we,   // Data strobe
  output logic [31:0]  o_chain_data, // Data word
  output trd_tmr_cmd_t o_tmr1_cmd,   // Timer 1 command
  output trd_tmr_cmd_t o_tmr2_cmd    // Timer 2 command
);
  int gap = 0;

  initial begin
    o_sel_we = 1'b0;
    o_sel_data = 8'h00;
    o_chain_we = 1'b0;
    o_chain_data = 32'h00000000;
    o_tmr1_cmd = '0;
    o_tmr2_cmd = '0;
  end

  task automatic wr_sel(input logic [7:0] s);
    @(posedge i_clk_sys) #2;
    o_sel_we = 1'b1;
    o_sel_data = s;
    @(posedge i_clk_sys) #2;
    o_sel_we = 1'b0;
  endtask : wr_sel

  task automatic wr_word(input logic [31:0] w);
    int n;
    @(posedge i_clk_sys) #2;
    o_chain_we = 1'b1;
    o_chain_data = w;
    @(posedge i_clk_sys) #2;
    o_chain_we = 1'b0;
    // Released bus shows a changed value
    o_chain_data = ~w;
    @(posedge i_clk_sys) #2;
    for (n = 0; n < 40 && i_busy !== 1'b0; n++) @(posedge i_clk_sys) #2;
    if (n == 40) begin
      trigger_range_edge_timer_bench.fail_count++;
      trigger_range_edge_timer_bench.give_verdict();
    end
    repeat (gap) @(posedge i_clk_sys) #2;
  endtask : wr_word

  task automatic wr_range(input int sel, input logic [31:0] t, m);
    logic [31:0] v;
    logic [15:0] c [2];
    int          k;
    v = sel[0] ? ~t : ~(t - 32'h1);
    v = v << (32 - $countones(m));
    wr_sel(8'(`TRD_SEL_RANGE_BASE + sel));
    for (k = 31; k >= 0; k--) begin
      if (!m[k]) begin
        c[k % 2] = `TRD_CMP_PASSTHROUGH;
      end else begin
        c[k % 2] = v[31] ? `TRD_CMP_TARGET_ONE : `TRD_CMP_TARGET_ZERO;
        v = v << 1;
      end
      if (k % 2 == 0) wr_word({c[1], c[0]});
    end
  endtask : wr_range

  task automatic wr_edge(input int sel, input logic [31:0] last);
    int k;
    wr_sel(8'(`TRD_SEL_EDGE1 + sel));
    for (k = 0; k < 7; k++) wr_word(32'h00000000);
    wr_word(last);
  endtask : wr_edge

  task automatic wr_limit(input int t, input logic [35:0] v);
    wr_sel(8'(`TRD_SEL_T1_LIM_LOW + 2 * t));
    wr_word(v[31:0]);
    wr_sel(8'(`TRD_SEL_T1_LIM_HIGH + 2 * t));
    wr_word({28'h0000000, v[35:32]});
  endtask : wr_limit

  task automatic tmr(input int t, input logic [2:0] c);
    @(posedge i_clk_sys) #2;
    if (t == 0) begin
      o_tmr1_cmd = trd_tmr_cmd_t'(c);
    end else begin
      o_tmr2_cmd = trd_tmr_cmd_t'(c);
    end
    @(posedge i_clk_sys) #2;
    o_tmr1_cmd = '0;
    o_tmr2_cmd = '0;
  endtask : tmr
endmodule : trd_host_model

// *** dv/trigger_range_edge_timer_bench.sv ***
`timescale 1ns/1ps
`include "trd_defines.svh"
module trigger_range_edge_timer_bench
  import trd_pkg::*;
;
  logic         clk;
  logic         rst_n;
  logic         sel_we;
  logic [7:0]   sel_data;
  logic         chain_we;
  logic [31:0]  chain_data;
  logic [31:0]  sample;
  trd_tmr_cmd_t tmr1;
  trd_tmr_cmd_t tmr2;
  trd_hits_t    hits;
  logic         busy;
  int           fail_count = 0;
  int           check_count = 0;

  trd_detectors dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_sel_we(sel_we),
    .i_sel_data(sel_data), .i_chain_we(chain_we),
    .i_chain_data(chain_data), .i_sample(sample), .i_tmr1_cmd(tmr1),
    .i_tmr2_cmd(tmr2), .o_hits(hits), .o_busy(busy));

  trd_host_model host (.i_clk_sys(clk), .i_busy(busy), .o_sel_we(sel_we),
    .o_sel_data(sel_data), .o_chain_we(chain_we),
    .o_chain_data(chain_data), .o_tmr1_cmd(tmr1), .o_tmr2_cmd(tmr2));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [35:0] exp, got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic step(input logic [31:0] s);
    @(posedge clk) #2;
    sample = s;
    repeat (2) @(posedge clk);
    #2;
  endtask : step

  function automatic logic [31:0] pick(input logic [31:0] s, m);
    int k;
    pick = '0;
    for (k = 31; k >= 0; k--)
      if (m[k]) pick = {pick[30:0], s[k]};
  endfunction : pick

  task automatic range_chk(input int r, input logic [31:0] lo, hi, m, s);
    logic [31:0] v;
    step(s);
    v = pick(s, m);
    check("range", 36'({v <= hi, v >= lo}),
          36'(r ? hits.range2 : hits.range1));
  endtask : range_chk

  task automatic test_ranges();
    logic [31:0] s1 [6] = '{32'hFF, 32'h100, 32'h1FF, 32'h200,
                            32'hFFFFFFFF, 32'h0};
    logic [31:0] s2 [6] = '{32'h1000, 32'hFFFF10FF, 32'h0F00, 32'h2100,
                            32'h20FF, 32'hEFFF};
    host.wr_range(0, 32'h100, 32'hFFFFFFFF);
    host.gap = 3;
    host.wr_range(1, 32'h1FF, 32'hFFFFFFFF);
    host.gap = 0;
    host.wr_range(2, 32'h10, 32'hFF00);
    host.wr_range(3, 32'h20, 32'hFF00);
    foreach (s1[i]) range_chk(0, 32'h100, 32'h1FF, 32'hFFFFFFFF, s1[i]);
    foreach (s2[i]) range_chk(1, 32'h10, 32'h20, 32'hFF00, s2[i]);
  endtask : test_ranges

  task automatic test_edges();
    logic [31:0] es [7] = '{32'h0, 32'h8, 32'h8, 32'h9, 32'h1, 32'h0,
                            32'hFFFFFFF7};
    logic [1:0]  ee [7] = '{2'b00, 2'b10, 2'b00, 2'b01, 2'b00, 2'b01,
                            2'b01};
    host.wr_edge(0, 32'h00CC0000);
    host.wr_edge(1, 32'h00005A5A);
    step(32'h0);
    foreach (es[i]) begin
      step(es[i]);
      check("edge", 36'(ee[i]), 36'({hits.edge1, hits.edge2}));
    end
  endtask : test_edges

  task automatic test_timers();
    int n;
    host.wr_limit(0, 36'h000000005);
    host.wr_limit(1, 36'h100000002);
    host.tmr(0, 3'b001);
    host.tmr(1, 3'b001);
    host.tmr(0, 3'b100);
    for (n = 1; n < 20 && hits.timer1 !== 1'b1; n++) @(posedge clk) #2;
    if (n == 20) begin
      fail_count++;
      give_verdict();
    end
    check("timer1_delay", 36'd7, 36'(n));
    host.tmr(0, 3'b001);
    check("timer1_clear", 36'h0, 36'(hits.timer1));
    host.tmr(0, 3'b100);
    host.tmr(0, 3'b010);
    repeat (20) @(posedge clk);
    #2;
    check("timer1_stop", 36'h0, 36'(hits.timer1));
    host.tmr(1, 3'b100);
    repeat (20) @(posedge clk);
    #2;
    check("timer2_high", 36'h0, 36'(hits.timer2));
  endtask : test_timers

  task automatic test_refuse();
    host.wr_sel(`TRD_SEL_EDGE2);
    fork
      host.wr_word(32'h00000000);
      begin
        repeat (2) @(posedge clk);
        host.wr_sel(`TRD_SEL_T1_LIM_LOW);
        check("busy_shift", 36'h1, 36'(busy));
        host.wr_word(32'h00000000);
      end
    join
    check("limit_refused", 36'h0, 36'(hits.timer1));
  endtask : test_refuse

  initial begin
    rst_n = 1'b0;
    sample = 32'h00000000;
    repeat (4) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    check("busy_reset", 36'h0, 36'(busy));
    test_ranges();
    test_edges();
    test_timers();
    test_refuse();
    give_verdict();
  end
endmodule : trigger_range_edge_timer_bench
